// *** hw/iec_regs.vh ***
`ifndef IEC_REGS_VH
`define IEC_REGS_VH
// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define IEC_OFS_EXT_CTRL    4'h0
`define IEC_OFS_MODE        4'h1
`define IEC_OFS_DATA        4'h2
`define IEC_OFS_STATUS      4'h3
`define IEC_OFS_CONTROL     4'h4
`define IEC_OFS_IRQ_STATUS  4'h5
`define IEC_OFS_IRQ_MASK    4'h6
// ---------------------------------------------------------------
// serial_ext_control fields
// ---------------------------------------------------------------
`define IEC_EXT_RATE_BIT    5
`define IEC_EXT_ACCESS_BIT  4
`define IEC_EXT_HANDSHAKE_RECEIVE_SELECT_BIT    3
`define IEC_EXT_WMASK       8'h38
`define IEC_EXT_RESET       8'h00
// ---------------------------------------------------------------
// serial_mode_reg and serial_status_reg fields
// ---------------------------------------------------------------
`define IEC_MODE_CKS_LSB    0
`define IEC_MODE_RESET      8'h00
`define IEC_STAT_FULL_BIT   0
`define IEC_STAT_EVENT_BIT  1
`define IEC_CTRL_RESET      8'h00
// ---------------------------------------------------------------
// interrupt status bits
// ---------------------------------------------------------------
`define IEC_IRQ_RX_BIT      0
`define IEC_IRQ_OVR_BIT     1
`define IEC_IRQ_DENY_BIT    2
`define IEC_IRQ_WMASK       8'h07
// ---------------------------------------------------------------
// divider periods in core clock cycles, per clock_divider_field
// ---------------------------------------------------------------
`define IEC_DIV_0           12'h01c
`define IEC_DIV_1           12'h028
`define IEC_DIV_2           12'h030
`define IEC_DIV_3           12'h040
`define IEC_DIV_4           12'h050
`define IEC_DIV_5           12'h064
`define IEC_DIV_6           12'h070
`define IEC_DIV_7           12'h080
`endif

// *** hw/iec_rate_div.v ***
`timescale 1ns/1ns
`default_nettype none
`include "iec_regs.vh"
module iec_rate_div (
  input  wire        core_clk_in,
  input  wire        arst_n_in,
  input  wire        rate_range_select_in,
  input  wire [2:0]  clock_divider_field_in,
  output wire        tick_out
);
  reg  [11:0] cnt_q;
  reg         tick_q;
  wire [11:0] base;
  wire [11:0] period;

  // ---------------------------------------------------------------
  // period decode
  // ---------------------------------------------------------------
  function [11:0] iec_base;
    input [2:0] cks;
    begin
      case (cks)
        3'h0:    iec_base = `IEC_DIV_0;
        3'h1:    iec_base = `IEC_DIV_1;
        3'h2:    iec_base = `IEC_DIV_2;
        3'h3:    iec_base = `IEC_DIV_3;
        3'h4:    iec_base = `IEC_DIV_4;
        3'h5:    iec_base = `IEC_DIV_5;
        3'h6:    iec_base = `IEC_DIV_6;
        default: iec_base = `IEC_DIV_7;
      endcase
    end
  endfunction

  // range select doubles the period
  assign base   = iec_base(clock_divider_field_in);
  assign period = rate_range_select_in ? {base[10:0], 1'b0} : base;

  always @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt_q  <= 12'h000;
      tick_q <= 1'b0;
    end else if (cnt_q >= period - 12'h001) begin
      cnt_q  <= 12'h000;
      tick_q <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + 12'h001;
      tick_q <= 1'b0;
    end
  end

  assign tick_out = tick_q;
endmodule // iec_rate_div
`default_nettype wire

// *** hw/iec_ext_ctrl.v ***
// Summary of operation
// - access enable gates interface register access
// - rate select plus divider field set rate
// - no handshake: receive continues while not full
// - handshake: hold clock low until data read
// - reserved extended control bits read zero
`timescale 1ns/1ns
`default_nettype none
`include "iec_regs.vh"
module iec_ext_ctrl (
  input  wire        core_clk_in,
  input  wire        arst_n_in,
  input  wire [3:0]  addr_in,
  input  wire [7:0]  wdata_in,
  input  wire        wr_in,
  input  wire        rd_in,
  output wire [7:0]  rdata_out,
  input  wire        rx_done_in,
  input  wire [7:0]  rx_byte_in,
  output wire        next_frame_en_out,
  output wire        scl_out,
  output wire        scl_oe_out,
  output wire        rate_tick_out,
  output wire [7:0]  serial_control_out,
  output wire        irq_out
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  reg  [7:0]  ext_q;
  reg  [7:0]  mode_q;
  reg  [7:0]  ctrl_q;
  reg  [7:0]  data_q;
  reg         full_q;
  reg         event_q;
  reg  [7:0]  irq_st_q;
  reg  [7:0]  irq_mask_q;
  reg  [7:0]  rdata_q;
  reg         irq_q;
  reg         next_en_q;
  reg         scl_oe_q;
  reg  [7:0]  ext_d;
  reg  [7:0]  mode_d;
  reg  [7:0]  ctrl_d;
  reg  [7:0]  data_d;
  reg         full_d;
  reg         event_d;
  reg  [7:0]  irq_st_d;
  reg  [7:0]  irq_mask_d;
  reg  [7:0]  rdata_d;
  wire        access_en;
  wire        gated_acc;
  wire        data_read;
  wire        tick;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  function iec_is_gated;
    input [3:0] a;
    begin
      iec_is_gated = (a == `IEC_OFS_MODE) || (a == `IEC_OFS_DATA) ||
                     (a == `IEC_OFS_STATUS) || (a == `IEC_OFS_CONTROL);
    end
  endfunction

  assign access_en = ext_q[`IEC_EXT_ACCESS_BIT];
  assign gated_acc = iec_is_gated(addr_in) & ~access_en;
  assign data_read = rd_in & access_en &
                     (addr_in == `IEC_OFS_DATA);

  // ---------------------------------------------------------------
  // rate divider
  // ---------------------------------------------------------------
  iec_rate_div u_div (
    .core_clk_in            (core_clk_in),
    .arst_n_in              (arst_n_in),
    .rate_range_select_in   (ext_q[`IEC_EXT_RATE_BIT]),
    .clock_divider_field_in (mode_q[`IEC_MODE_CKS_LSB+2:`IEC_MODE_CKS_LSB]),
    .tick_out               (tick)
  );

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always @* begin
    ext_d      = ext_q;
    mode_d     = mode_q;
    ctrl_d     = ctrl_q;
    data_d     = data_q;
    full_d     = full_q;
    event_d    = event_q;
    irq_st_d   = irq_st_q;
    irq_mask_d = irq_mask_q;
    rdata_d    = 8'h00;
    // register writes
    if (wr_in && !gated_acc) begin
      case (addr_in)
        `IEC_OFS_EXT_CTRL:  ext_d = wdata_in & `IEC_EXT_WMASK;
        `IEC_OFS_MODE:      mode_d = wdata_in;
        `IEC_OFS_CONTROL:   ctrl_d = wdata_in;
        `IEC_OFS_STATUS: begin
          if (!wdata_in[`IEC_STAT_EVENT_BIT])
            event_d = 1'b0;
        end
        `IEC_OFS_IRQ_STATUS:
          irq_st_d = irq_st_q & ~(wdata_in & `IEC_IRQ_WMASK);
        `IEC_OFS_IRQ_MASK:  irq_mask_d = wdata_in & `IEC_IRQ_WMASK;
        default: ;
      endcase
    end
    // read of data releases the held clock
    if (data_read)
      full_d = 1'b0;
    // register reads
    if (rd_in && !gated_acc) begin
      case (addr_in)
        `IEC_OFS_EXT_CTRL:   rdata_d = ext_q & `IEC_EXT_WMASK;
        `IEC_OFS_MODE:       rdata_d = mode_q;
        `IEC_OFS_DATA:       rdata_d = data_q;
        `IEC_OFS_STATUS: begin
          rdata_d[`IEC_STAT_FULL_BIT]  = full_q;
          rdata_d[`IEC_STAT_EVENT_BIT] = event_q;
        end
        `IEC_OFS_CONTROL:    rdata_d = ctrl_q;
        `IEC_OFS_IRQ_STATUS: rdata_d = irq_st_q;
        `IEC_OFS_IRQ_MASK:   rdata_d = irq_mask_q;
        default:             rdata_d = 8'h00;
      endcase
    end
    // blocked access event
    if ((wr_in || rd_in) && gated_acc)
      irq_st_d[`IEC_IRQ_DENY_BIT] = 1'b1;
    // received byte: set wins over any clear
    if (rx_done_in) begin
      if (full_q && !data_read)
        irq_st_d[`IEC_IRQ_OVR_BIT] = 1'b1;
      else
        data_d = rx_byte_in;
      full_d  = 1'b1;
      event_d = 1'b1;
      irq_st_d[`IEC_IRQ_RX_BIT] = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ext_q      <= `IEC_EXT_RESET;
      mode_q     <= `IEC_MODE_RESET;
      ctrl_q     <= `IEC_CTRL_RESET;
      data_q     <= 8'h00;
      full_q     <= 1'b0;
      event_q    <= 1'b0;
      irq_st_q   <= 8'h00;
      irq_mask_q <= 8'h00;
      rdata_q    <= 8'h00;
      irq_q      <= 1'b0;
      next_en_q  <= 1'b1;
      scl_oe_q   <= 1'b0;
    end else begin
      ext_q      <= ext_d;
      mode_q     <= mode_d;
      ctrl_q     <= ctrl_d;
      data_q     <= data_d;
      full_q     <= full_d;
      event_q    <= event_d;
      irq_st_q   <= irq_st_d;
      irq_mask_q <= irq_mask_d;
      rdata_q    <= rdata_d;
      irq_q      <= |(irq_st_d & irq_mask_d);
      next_en_q  <= ~full_d;
      scl_oe_q   <= ext_d[`IEC_EXT_HANDSHAKE_RECEIVE_SELECT_BIT] & full_d;
    end
  end

  assign rdata_out          = rdata_q;
  assign next_frame_en_out  = next_en_q;
  assign scl_out            = 1'b0;
  assign scl_oe_out         = scl_oe_q;
  assign rate_tick_out      = tick;
  assign serial_control_out = ctrl_q;
  assign irq_out            = irq_q;
endmodule // iec_ext_ctrl
`default_nettype wire

// *** bench/iec_ext_ctrl_props.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "iec_regs.vh"
module iec_ext_ctrl_props (
  input wire logic       core_clk_in,
  input wire logic       arst_n_in,
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic       wr_in,
  input wire logic       rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic       rx_done_in,
  input wire logic       next_frame_en_out,
  input wire logic       scl_oe_out
);
  logic acc_q;
  logic handshake_receive_select_q;
  wire  ext_wr = wr_in && addr_in == `IEC_OFS_EXT_CTRL;
  wire  gated  = addr_in >= `IEC_OFS_MODE && addr_in <= `IEC_OFS_CONTROL;
  wire  dat_rd = rd_in && addr_in == `IEC_OFS_DATA && acc_q && !rx_done_in;
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      acc_q  <= 1'b0;
      handshake_receive_select_q <= 1'b0;
    end else if (ext_wr) begin
      acc_q  <= wdata_in[`IEC_EXT_ACCESS_BIT];
      handshake_receive_select_q <= wdata_in[`IEC_EXT_HANDSHAKE_RECEIVE_SELECT_BIT];
    end
  end
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!arst_n_in);
  chk_deny_read_zero: assert property (
    rd_in && gated && !acc_q |=> rdata_out == 8'h00)
    else $error("denied read not zero");
  chk_rsvd_read_zero: assert property (
    rd_in && addr_in == `IEC_OFS_EXT_CTRL |=> (rdata_out & 8'hc4) == 8'h00)
    else $error("reserved bits not zero");
  chk_hold_on_rx: assert property (
    rx_done_in && handshake_receive_select_q |=> scl_oe_out) else $error("clock not held");
  chk_release_on_read: assert property (
    dat_rd |=> !scl_oe_out) else $error("clock not released");
  chk_stop_when_full: assert property (
    rx_done_in |=> !next_frame_en_out) else $error("frame not stopped");
  chk_resume_after_read: assert property (
    dat_rd |=> next_frame_en_out) else $error("frame not resumed");
  chk_no_hold_cont: assert property (
    !handshake_receive_select_q && !scl_oe_out && !ext_wr |=> !scl_oe_out)
    else $error("clock held in continuous mode");
  cov_hold: cover property (rx_done_in && handshake_receive_select_q);
  cov_deny: cover property (rd_in && gated && !acc_q);
  cov_read: cover property (dat_rd);
endmodule // iec_ext_ctrl_props
bind iec_ext_ctrl iec_ext_ctrl_props i_iec_ext_ctrl_props (
  .core_clk_in(core_clk_in), .arst_n_in(arst_n_in), .addr_in(addr_in),
  .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
  .rx_done_in(rx_done_in), .next_frame_en_out(next_frame_en_out),
  .scl_oe_out(scl_oe_out));
`default_nettype wire

// *** bench/iec_rx_src.sv ***
`timescale 1ns/1ns
`default_nettype none
module iec_rx_src (
  input  wire logic       core_clk_in,
  input  wire logic       arst_n_in,
  input  wire logic       go_in,
  input  wire logic [7:0] byte_in,
  input  wire logic       next_frame_en_in,
  input  wire logic       scl_held_in,
  output logic            rx_done_out,
  output logic      [7:0] rx_byte_out
);
  wire fire = go_in && next_frame_en_in && !scl_held_in;
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rx_done_out <= 1'b0;
      rx_byte_out <= 8'h00;
    end else begin
      rx_done_out <= fire;
      rx_byte_out <= fire ? byte_in : ~rx_byte_out;
    end
  end
endmodule // iec_rx_src
`default_nettype wire

// *** bench/tb_iec_ext_ctrl.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "iec_regs.vh"
module tb_iec_ext_ctrl;
  logic       clk = 0, arst_n = 0, wr = 0, rd = 0, go = 0;
  logic [3:0] addr = 0;
  logic [7:0] wdata = 0, rx_b = 0, v, b;
  wire  [7:0] rdata, rx_byte, ctl;
  wire        rx_done, nfe, scl, oe, tick, irq;
  int         num_errors = 0, samples_checked = 0, n;
  integer     seed = 32'hb681;
  always #5 clk = ~clk;
  iec_ext_ctrl i_iec_ext_ctrl (.core_clk_in(clk), .arst_n_in(arst_n),
    .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
    .rdata_out(rdata), .rx_done_in(rx_done), .rx_byte_in(rx_byte),
    .next_frame_en_out(nfe), .scl_out(scl), .scl_oe_out(oe),
    .rate_tick_out(tick), .serial_control_out(ctl), .irq_out(irq));
  iec_rx_src i_iec_rx_src (.core_clk_in(clk), .arst_n_in(arst_n),
    .go_in(go), .byte_in(rx_b), .next_frame_en_in(nfe),
    .scl_held_in(oe), .rx_done_out(rx_done), .rx_byte_out(rx_byte));
  task chk(input logic [15:0] s, e);
    samples_checked++;
    if (s !== e) begin
      num_errors++;
      $display("MISMATCH %0t: got %h exp %h", $time, s, e);
    end
  endtask
  task wr_r(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk); addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk); wr <= 1'b0;
  endtask
  task rd_r(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk); addr <= a; rd <= 1'b1;
    @(posedge clk); rd <= 1'b0;
    #1 d = rdata;
  endtask
  task send(input logic [7:0] d);
    @(posedge clk); go <= 1'b1; rx_b <= d;
    @(posedge clk); go <= 1'b0;
    @(posedge clk); #1;
  endtask
  task tick_per(output int c);
    repeat (300) begin @(posedge clk); #1; if (tick === 1'b1) break; end
    c = 0;
    do begin @(posedge clk); #1; c++; end while (tick !== 1'b1 && c < 300);
  endtask
  function logic [15:0] exp_per(input logic [2:0] f, input logic r);
    logic [11:0] p;
    case (f)
      3'h0: p = `IEC_DIV_0;   3'h1: p = `IEC_DIV_1;
      3'h2: p = `IEC_DIV_2;   3'h3: p = `IEC_DIV_3;
      3'h4: p = `IEC_DIV_4;   3'h5: p = `IEC_DIV_5;
      3'h6: p = `IEC_DIV_6;   default: p = `IEC_DIV_7;
    endcase
    return {4'h0, p} << r;
  endfunction
  task finish_test;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    rd_r(`IEC_OFS_EXT_CTRL, v); chk(v, `IEC_EXT_RESET);
    wr_r(`IEC_OFS_MODE, 8'h05);
    rd_r(`IEC_OFS_MODE, v); chk(v, 8'h00);
    wr_r(`IEC_OFS_CONTROL, 8'h5a); #1 chk(ctl, 8'h00);
    wr_r(`IEC_OFS_IRQ_MASK, 8'h04); @(posedge clk); #1 chk(irq, 1'b1);
    wr_r(`IEC_OFS_IRQ_STATUS, 8'h04); @(posedge clk); #1 chk(irq, 1'b0);
    v = 8'($random(seed)) | 8'h10; wr_r(`IEC_OFS_EXT_CTRL, v);
    rd_r(`IEC_OFS_EXT_CTRL, b); chk(b, v & `IEC_EXT_WMASK);
    wr_r(`IEC_OFS_CONTROL, b ^ 8'ha5); #1 chk(ctl, b ^ 8'ha5);
    $display("test access done");
    for (int i = 0; i < 16; i++) begin
      wr_r(`IEC_OFS_EXT_CTRL, {2'h0, i[0], 1'h1, 4'h0});
      wr_r(`IEC_OFS_MODE, {5'h00, i[3:1]});
      tick_per(n); chk(n[15:0], exp_per(i[3:1], i[0]));
    end
    rd_r(`IEC_OFS_MODE, v); chk(v & 8'h07, 8'h07);
    $display("test rate done");
    for (int h = 0; h < 2; h++) begin
      wr_r(`IEC_OFS_EXT_CTRL, {4'h1, h[0], 3'h0});
      b = 8'($random(seed)); send(b);
      chk(oe, h[0]);
      chk(nfe, 1'b0);
      chk(scl, 1'b0);
      wr_r(`IEC_OFS_EXT_CTRL, {4'h0, h[0], 3'h0});
      rd_r(`IEC_OFS_DATA, v); chk(v, 8'h00);
      chk(irq, 1'b1);
      chk(nfe, 1'b0);
      chk(oe, h[0]);
      wr_r(`IEC_OFS_IRQ_STATUS, 8'h04);
      wr_r(`IEC_OFS_EXT_CTRL, {4'h1, h[0], 3'h0});
      rd_r(`IEC_OFS_STATUS, v); chk(v & 8'h03, 8'h03);
      rd_r(`IEC_OFS_DATA, v); chk(v, b);
      chk(oe, 1'b0);
      chk(nfe, 1'b1);
      wr_r(`IEC_OFS_STATUS, 8'h00);
      rd_r(`IEC_OFS_STATUS, v); chk(v & 8'h03, 8'h00);
    end
    $display("test receive done");
    finish_test;
  end
  initial begin
    #300000;
    num_errors++;
    finish_test;
  end
endmodule // tb_iec_ext_ctrl
`default_nettype wire
